// ==== rtl/fro_pkg.sv ====
// Package of constants and types for the fault retry and output good block
package fro_pkg;

  // Command codes of the word settings
  localparam logic [7:0] CMD_OUTPUT_GOOD_ASSERT_LEVEL = 8'h5E;
  localparam logic [7:0] CMD_OUTPUT_GOOD_NEGATE_LEVEL = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_DELAY_TIME       = 8'h60;

  // Register file indices
  localparam int unsigned NUM_REGS       = 3;
  localparam logic [1:0]  IDX_ASSERT_LVL = 2'h0;
  localparam logic [1:0]  IDX_NEGATE_LVL = 2'h1;
  localparam logic [1:0]  IDX_TURN_ON_DELAY_TIME  = 2'h2;
  localparam logic [1:0]  IDX_NONE       = 2'h3;

  // Values after reset
  localparam logic [15:0] RST_ASSERT_LVL = 16'h0000;
  localparam logic [15:0] RST_NEGATE_LVL = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_DELAY_TIME  = 16'h0000;

  // Fault response byte fields
  localparam int unsigned RESP_MSB      = 7;
  localparam int unsigned RESP_LSB      = 6;
  localparam int unsigned RETRY_MSB     = 5;
  localparam int unsigned RETRY_LSB     = 3;
  localparam int unsigned TIME_MSB      = 2;
  localparam int unsigned TIME_LSB      = 0;

  localparam logic [1:0] RESP_IGNORE     = 2'h0;
  localparam logic [1:0] RESP_RUN_DELAY  = 2'h1;
  localparam logic [1:0] RESP_DIS_RETRY  = 2'h2;
  localparam logic [1:0] RESP_DIS_LATCH  = 2'h3;

  localparam logic [2:0] RETRY_NONE      = 3'h0;
  localparam logic [2:0] RETRY_FOREVER   = 3'h7;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned MS_IN_NS        = 1000000;
  localparam int unsigned CYCLES_PER_MS   = MS_IN_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_TON_WAIT,
    ST_ON,
    ST_FLT_RUN,
    ST_RETRY_WAIT,
    ST_LATCHED
  } fro_state_e;

endpackage

// ==== rtl/fro_timer_if.sv ====
// Interface between the sequencer and its delay timer
`timescale 1ns/1ns
interface fro_timer_if;
  logic        start;
  logic [15:0] units;
  logic [15:0] unit_cycles;
  logic        done;
  logic        busy;

  modport ctrl  (output start, units, unit_cycles, input done, busy);
  modport timer (input start, units, unit_cycles, output done, busy);
endinterface

// ==== rtl/fro_delay_timer.sv ====
// Delay timer counting whole units of a programmable cycle length
`timescale 1ns/1ns
module fro_delay_timer
  import fro_pkg::*;
(
  input  wire logic    i_core_clk,
  input  wire logic    i_rst_b,
  fro_timer_if.timer   tmr
);

  logic [15:0] left_q;
  logic [15:0] cyc_q;
  logic [15:0] ucyc_q;
  logic        busy_q;
  logic        done_q;
  logic        last_unit;

  assign last_unit = (cyc_q + 16'h0001 >= ucyc_q) && (left_q == 16'h0001);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      left_q <= 16'h0000;
      cyc_q  <= 16'h0000;
      ucyc_q <= 16'h0001;
      busy_q <= 1'b0;
    end else if (tmr.start) begin
      left_q <= tmr.units;
      cyc_q  <= 16'h0000;
      ucyc_q <= (tmr.unit_cycles == 16'h0000) ? 16'h0001 : tmr.unit_cycles;
      busy_q <= (tmr.units != 16'h0000);
    end else if (busy_q) begin
      if (cyc_q + 16'h0001 >= ucyc_q) begin
        cyc_q  <= 16'h0000;
        left_q <= left_q - 16'h0001;
        if (left_q == 16'h0001) begin
          busy_q <= 1'b0;
        end
      end else begin
        cyc_q <= cyc_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= tmr.start ? (tmr.units == 16'h0000) : (busy_q && last_unit);
    end
  end

  assign tmr.done = done_q;
  assign tmr.busy = busy_q;

endmodule // fro_delay_timer

// ==== rtl/fro_sequencer.sv ====
// Fault retry sequencer, output good detector and word settings
// Notes on behaviour
// - Retry codes 1-6 give that many restarts.
// - Code 111 retries until off or shutdown.
// - Retry time is two to field units.
// - Delay serves running time or retry interval.
// - Delay unit length comes from unit setting.
// - Assert output good at assert threshold.
// - Negate output good below negate threshold.
// - Status bit is one while output good is negated.
// - Wait turn-on delay milliseconds before rising.
// - All three settings support word read, write.
// - Response field picks ignore/run/retry/latch handling.
// - Retry code zero latches output off.
`timescale 1ns/1ns
module fro_sequencer
  import fro_pkg::*;
#(
  parameter logic [15:0] P_CYCLES_PER_MS = 16'(CYCLES_PER_MS)
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // Word command port
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_wdata,
  output logic             o_cmd_ack,
  output logic             o_cmd_rvalid,
  output logic [15:0]      o_cmd_rdata,
  // Fault handling setup and events
  input  wire logic [7:0]  i_fault_response,
  input  wire logic [15:0] i_time_unit_cycles,
  input  wire logic        i_fault,
  input  wire logic        i_fault_clear,
  input  wire logic        i_other_shutdown,
  input  wire logic        i_enable,
  input  wire logic        i_bias_ok,
  // Output voltage monitoring
  input  wire logic [15:0] i_vout,
  input  wire logic        i_multi_pin_setup_good_en,
  // Power stage control and status
  output logic             o_output_on,
  output logic             o_rise_start,
  output logic             o_latched_off,
  output logic [2:0]       o_attempts,
  output logic             o_output_good_signal,
  output logic             o_output_good_status
);

  // Command code to register index
  function automatic logic [1:0] code_to_idx(input logic [7:0] code);
    case (code)
      CMD_OUTPUT_GOOD_ASSERT_LEVEL: code_to_idx = IDX_ASSERT_LVL;
      CMD_OUTPUT_GOOD_NEGATE_LEVEL: code_to_idx = IDX_NEGATE_LVL;
      CMD_TURN_ON_DELAY_TIME:       code_to_idx = IDX_TURN_ON_DELAY_TIME;
      default:                      code_to_idx = IDX_NONE;
    endcase
  endfunction

  // Whether another restart is allowed for this retry code
  function automatic logic may_retry(input logic [2:0] code, input logic [2:0] done_cnt);
    if (code == RETRY_NONE) begin
      may_retry = 1'b0;
    end else if (code == RETRY_FOREVER) begin
      may_retry = 1'b1;
    end else begin
      may_retry = (done_cnt < code);
    end
  endfunction

  localparam logic [15:0] RST_VALS [NUM_REGS] = '{RST_ASSERT_LVL, RST_NEGATE_LVL, RST_TURN_ON_DELAY_TIME};

  logic [15:0] regs_q [NUM_REGS];
  logic [1:0]  cmd_idx;
  logic        cmd_hit;
  logic [15:0] rdata_q;
  logic        rvalid_q;

  // Command decode
  assign cmd_idx   = code_to_idx(i_cmd_code);
  assign cmd_hit   = (cmd_idx != IDX_NONE);
  assign o_cmd_ack = i_cmd_valid && cmd_hit;

  // Word writes, one per setting
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          regs_q[g] <= RST_VALS[g];
        end else if (i_cmd_valid && i_cmd_write && cmd_idx == 2'(g)) begin
          regs_q[g] <= i_cmd_wdata;
        end
      end
    end
  endgenerate

  // Word reads
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_cmd_valid && !i_cmd_write && cmd_hit;
      if (i_cmd_valid && !i_cmd_write && cmd_hit) begin
        rdata_q <= regs_q[cmd_idx];
      end
    end
  end

  assign o_cmd_rvalid = rvalid_q;
  assign o_cmd_rdata  = rdata_q;

  // Fault response fields
  logic [1:0]  resp;
  logic [2:0]  retry_code;
  logic [2:0]  time_code;
  logic [15:0] delay_units;

  assign resp        = i_fault_response[RESP_MSB:RESP_LSB];
  assign retry_code  = i_fault_response[RETRY_MSB:RETRY_LSB];
  assign time_code   = i_fault_response[TIME_MSB:TIME_LSB];
  assign delay_units = 16'h0001 << time_code;

  // Delay timer
  fro_timer_if tmr_if ();

  fro_delay_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .tmr        (tmr_if.timer)
  );

  // Fault handling state
  fro_state_e  state_q;
  fro_state_e  state_d;
  logic [2:0]  attempts_q;
  logic        attempt_inc;
  logic        attempt_clr;
  logic        tmr_start;
  logic [15:0] tmr_units;
  logic [15:0] tmr_ucyc;
  logic        rise_d;
  logic        rise_q;
  logic        on_q;

  assign tmr_if.start       = tmr_start;
  assign tmr_if.units       = tmr_units;
  assign tmr_if.unit_cycles = tmr_ucyc;

  // Expiry of the current count only
  logic tmr_fired;

  assign tmr_fired = tmr_if.done && !tmr_if.busy;

  // Next state of the sequencer
  always_comb begin
    state_d     = state_q;
    attempt_inc = 1'b0;
    attempt_clr = 1'b0;
    tmr_start   = 1'b0;
    tmr_units   = delay_units;
    tmr_ucyc    = i_time_unit_cycles;
    rise_d      = 1'b0;
    if (!i_enable || !i_bias_ok) begin
      state_d     = ST_OFF;
      attempt_clr = 1'b1;
    end else if (i_other_shutdown && state_q != ST_OFF) begin
      state_d = ST_LATCHED;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_d   = ST_TON_WAIT;
          tmr_start = 1'b1;
          tmr_units = regs_q[IDX_TURN_ON_DELAY_TIME];
          tmr_ucyc  = P_CYCLES_PER_MS;
        end
        ST_TON_WAIT: begin
          if (tmr_fired) begin
            state_d = ST_ON;
            rise_d  = 1'b1;
          end
        end
        ST_ON: begin
          if (i_fault) begin
            case (resp)
              RESP_IGNORE: state_d = ST_ON;
              RESP_RUN_DELAY: begin
                state_d   = ST_FLT_RUN;
                tmr_start = 1'b1;
              end
              RESP_DIS_RETRY: begin
                if (may_retry(retry_code, attempts_q)) begin
                  state_d     = ST_RETRY_WAIT;
                  tmr_start   = 1'b1;
                  attempt_inc = (retry_code != RETRY_FOREVER);
                end else begin
                  state_d = ST_LATCHED;
                end
              end
              default: state_d = ST_LATCHED;
            endcase
          end
        end
        ST_FLT_RUN: begin
          if (tmr_fired) begin
            if (!i_fault) begin
              state_d = ST_ON;
            end else if (may_retry(retry_code, attempts_q)) begin
              state_d     = ST_RETRY_WAIT;
              tmr_start   = 1'b1;
              attempt_inc = (retry_code != RETRY_FOREVER);
            end else begin
              state_d = ST_LATCHED;
            end
          end
        end
        ST_RETRY_WAIT: begin
          if (tmr_fired) begin
            state_d = ST_ON;
            rise_d  = 1'b1;
          end
        end
        ST_LATCHED: begin
          if (i_fault_clear) begin
            state_d     = ST_OFF;
            attempt_clr = 1'b1;
          end
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Restart attempts
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      attempts_q <= 3'h0;
    end else if (attempt_clr || (i_fault_clear && state_q != ST_LATCHED)) begin
      attempts_q <= 3'h0;
    end else if (attempt_inc) begin
      attempts_q <= attempts_q + 3'h1;
    end
  end

  // Power stage outputs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_q   <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      on_q   <= (state_d == ST_ON) || (state_d == ST_FLT_RUN);
      rise_q <= rise_d;
    end
  end

  assign o_output_on   = on_q;
  assign o_rise_start  = rise_q;
  assign o_latched_off = (state_q == ST_LATCHED);
  assign o_attempts    = attempts_q;

  // Output good with hysteresis between the two levels
  logic good_q;
  logic pin_q;
  logic above_assert;
  logic below_negate;

  assign above_assert = (i_vout >= regs_q[IDX_ASSERT_LVL]);
  assign below_negate = (i_vout < regs_q[IDX_NEGATE_LVL]);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      good_q <= 1'b0;
    end else if (below_negate) begin
      good_q <= 1'b0;
    end else if (above_assert) begin
      good_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= i_multi_pin_setup_good_en && !below_negate && (good_q || above_assert);
    end
  end

  assign o_output_good_signal = pin_q;
  assign o_output_good_status = !good_q;

endmodule // fro_sequencer

// ==== dv/fro_host_model.sv ====
// Host model issuing word commands to the sequencer
`timescale 1ns/1ns
module fro_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_ack,
  input  wire logic        i_rvalid,
  input  wire logic [15:0] i_rdata,
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic [15:0]      o_wdata
);
  initial {o_valid, o_write, o_code, o_wdata} = 26'h0000000;
  // One whole word per request, held across the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic ak, output logic rv, output logic [15:0] rd);
    @(negedge i_core_clk);
    {o_valid, o_write, o_code, o_wdata} = {1'h1, w, c, d};
    @(posedge i_core_clk);
    ak = i_ack;
    @(negedge i_core_clk);
    o_valid = 1'h0;
    o_wdata = ~d;
    rv = i_rvalid;
    rd = i_rdata;
  endtask
endmodule // fro_host_model

// ==== dv/fro_sequencer_properties.sv ====
// Port checker of the sequencer
`timescale 1ns/1ns
module fro_sequencer_properties (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic       i_cmd_valid,
  input wire logic       i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic       o_cmd_ack,
  input wire logic       o_cmd_rvalid,
  input wire logic [7:0] i_fault_response,
  input wire logic       i_fault,
  input wire logic       i_other_shutdown,
  input wire logic       i_enable,
  input wire logic       i_bias_ok,
  input wire logic       i_multi_pin_setup_good_en,
  input wire logic       o_output_on,
  input wire logic       o_rise_start,
  input wire logic       o_latched_off,
  input wire logic [2:0] o_attempts,
  input wire logic       o_output_good_signal,
  input wire logic       o_output_good_status
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_read;
    i_cmd_valid && !i_cmd_write && o_cmd_ack;
  endsequence
  sequence s_on_steady;
    o_output_on && i_enable && i_bias_ok && !i_other_shutdown;
  endsequence
  chk_read_answer: assert property (s_read |=> o_cmd_rvalid)
    else $error("read without rvalid");
  chk_odd_code: assert property (i_cmd_valid && !(i_cmd_code inside {8'h5E, 8'h5F, 8'h60})
    |-> !o_cmd_ack ##1 !o_cmd_rvalid) else $error("odd code answered");
  chk_rise_pulse: assert property ($rose(o_rise_start) |=> !o_rise_start)
    else $error("rise start too long");
  chk_rise_on: assert property (o_rise_start |-> o_output_on)
    else $error("rise without output on");
  chk_latch_off: assert property (o_latched_off |-> !o_output_on)
    else $error("latched but on");
  chk_retry_cap: assert property (i_fault_response[5:3] != 3'h7
    |-> o_attempts <= i_fault_response[5:3]) else $error("too many restarts");
  chk_no_retry: assert property (s_on_steady ##0 ($rose(i_fault) && i_fault_response == 8'h80)
    |-> ##[1:3] o_latched_off) else $error("code zero not latched");
  chk_ignore_fault: assert property (s_on_steady ##0 (i_fault && i_fault_response[7:6] == 2'h0)
    |=> o_output_on) else $error("ignored fault stopped output");
  chk_bias_lost: assert property (!i_bias_ok |-> ##[1:2] !o_output_on)
    else $error("on without bias");
  chk_shutdown_latch: assert property (i_other_shutdown && i_enable && i_bias_ok && !o_latched_off
    |-> ##[1:2] o_latched_off) else $error("shutdown did not latch");
  chk_pin_gate: assert property (!i_multi_pin_setup_good_en |=> !o_output_good_signal)
    else $error("pin good while disabled");
  chk_pin_status: assert property (o_output_good_signal |-> !o_output_good_status)
    else $error("status not good with pin good");
endmodule // fro_sequencer_properties

// ==== dv/test_fault_retry_and_output_good.sv ====
// Self-checking bench of the fault retry and output good block
`timescale 1ns/1ns
module test_fault_retry_and_output_good;
  import fro_pkg::*;
  localparam logic [15:0] P_MS = 16'h0004;
  localparam logic [15:0] UNIT = 16'h0003;
  logic        i_core_clk = 1'h0, i_rst_b = 1'h0, i_fault = 1'h0, i_fault_clear = 1'h0;
  logic        i_other_shutdown = 1'h0, i_enable = 1'h0, i_bias_ok = 1'h1;
  logic        i_multi_pin_setup_good_en = 1'h0, i_cmd_valid, i_cmd_write, ak, rv, g;
  logic [7:0]  i_cmd_code, i_fault_response = 8'h00;
  logic [15:0] i_cmd_wdata, i_vout = 16'h0000, i_time_unit_cycles = UNIT;
  logic        o_cmd_ack, o_cmd_rvalid, o_output_on, o_rise_start, o_latched_off;
  logic        o_output_good_signal, o_output_good_status;
  logic [15:0] o_cmd_rdata, rd, lfsr = 16'h004C;
  logic [2:0]  o_attempts;
  logic [7:0]  rtab [8] = '{8'hA0, 8'hA8, 8'hB0, 8'h80, 8'hE0, 8'h60, 8'h20, 8'hB8};
  logic [15:0] vtab [6] = '{16'h9000, 16'h6000, 16'h3000, 16'h8000, 16'h4000, 16'h3FFF};
  int          bad_count = 0, check_count = 0, n, i;

  always #50 i_core_clk = ~i_core_clk;
  fro_sequencer #(.P_CYCLES_PER_MS(P_MS)) uut (.*);
  fro_host_model host (.i_core_clk, .i_ack(o_cmd_ack), .i_rvalid(o_cmd_rvalid),
    .i_rdata(o_cmd_rdata), .o_valid(i_cmd_valid), .o_write(i_cmd_write),
    .o_code(i_cmd_code), .o_wdata(i_cmd_wdata));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int gap(input logic [2:0] t);
    return (1 << t) * UNIT;
  endfunction
  // Restarts expected, -1 for unlimited
  function automatic int exp_starts(input logic [7:0] r);
    if (r[7:6] == 2'h0 || r[7:6] == 2'h3) return 0;
    return r[5:3] == 3'h7 ? -1 : int'(r[5:3]);
  endfunction

  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic run_fault(input logic [7:0] r);
    int starts, last, gp, off, ex, span;
    ex = exp_starts(r);
    // Running on with the fault adds one delay before each wait
    span = r[7:6] == 2'h1 ? 2 * gap(r[2:0]) : gap(r[2:0]);
    @(negedge i_core_clk);
    {i_fault, i_fault_clear, i_enable, i_bias_ok} = 4'h7;
    @(negedge i_core_clk);
    i_fault_clear = 1'h0;
    i_fault_response = r;
    for (n = 0; n < 80 && o_output_on !== 1'h1; n++) @(negedge i_core_clk);
    check(o_output_on === 1'h1 && o_attempts === 3'h0, "restart after clear");
    i_fault = 1'h1;
    starts = 0;
    gp = 0;
    off = 0;
    last = 0;
    for (n = 1; n < 600 && o_latched_off !== 1'h1; n++) begin
      @(negedge i_core_clk);
      if (o_output_on !== 1'h1 && off == 0) off = n;
      if (o_rise_start === 1'h1) begin
        if (starts == 1) gp = n - last;
        starts++;
        last = n;
      end
    end
    check(ex < 0 ? starts > 8 : starts == ex, "restart count");
    check(o_latched_off === (r[7:6] != 2'h0 && r[5:3] != 3'h7), "latched state");
    if (ex >= 0) check(o_attempts === ex[2:0], "attempt count");
    case (r[7:6])
      2'h0: check(off == 0, "fault ignored");
      2'h1: check(off >= gap(r[2:0]), "run before retry");
      default: check(off > 0 && off < 4, "prompt disable");
    endcase
    if (gp != 0) check(gp >= span && gp <= span + 6, "retry interval");
    if (ex < 0) begin
      i_other_shutdown = 1'h1;
      repeat (3) @(negedge i_core_clk);
      check(o_latched_off === 1'h1 && o_output_on === 1'h0, "shutdown stop");
      i_other_shutdown = 1'h0;
      i_bias_ok = 1'h0;
      repeat (3) @(negedge i_core_clk);
      check(o_output_on === 1'h0 && o_rise_start === 1'h0, "bias loss stop");
      check(o_latched_off === 1'h0, "bias loss clears latch");
    end
  endtask

  initial begin
    repeat (16) @(negedge i_core_clk);
    check(o_output_good_status === 1'h1 && o_output_on === 1'h0, "reset outputs");
    i_rst_b = 1'h1;
    for (n = 0; n < 3; n++) begin
      host.xfer(1'h0, 8'h5E + 8'(n), 16'h0000, ak, rv, rd);
      check(ak === 1'h1 && rv === 1'h1 && rd === 16'h0000, "reset value");
    end
    for (i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      host.xfer(1'h1, 8'h5E + 8'(i % 3), lfsr, ak, rv, rd);
      host.xfer(1'h0, 8'h5E + 8'(i % 3), 16'h0000, ak, rv, rd);
      check(rd === lfsr && rv === 1'h1, "readback");
    end
    host.xfer(1'h1, 8'h61, 16'hFFFF, ak, rv, rd);
    host.xfer(1'h0, 8'h61, 16'h0000, ak, rv, rd);
    check(ak === 1'h0 && rv === 1'h0, "unsupported code");
    host.xfer(1'h1, 8'h5E, 16'h8000, ak, rv, rd);
    host.xfer(1'h1, 8'h5F, 16'h4000, ak, rv, rd);
    host.xfer(1'h1, 8'h60, 16'h0002, ak, rv, rd);
    i_multi_pin_setup_good_en = 1'h1;
    g = 1'h0;
    for (i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      i_vout = i < 6 ? vtab[i] : lfsr;
      g = i_vout >= 16'h8000 ? 1'h1 : (i_vout < 16'h4000 ? 1'h0 : g);
      repeat (2) @(negedge i_core_clk);
      check(o_output_good_signal === g && o_output_good_status === !g, "output good");
    end
    i_multi_pin_setup_good_en = 1'h0;
    repeat (2) @(negedge i_core_clk);
    check(o_output_good_signal === 1'h0 && o_output_good_status === !g, "pin gated");
    i_enable = 1'h1;
    for (n = 0; n < 60 && o_rise_start !== 1'h1; n++) @(negedge i_core_clk);
    check(n >= 2 * P_MS + 1 && n <= 2 * P_MS + 5, "turn-on delay");
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      run_fault(rtab[i][5:3] == 3'h0 ? rtab[i] : rtab[i] | {6'h00, lfsr[1:0]});
    end
    test_done();
  end

  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule // test_fault_retry_and_output_good

bind fro_sequencer fro_sequencer_properties chk (.*);
